// file: shared/fseq_defines.vh
`ifndef FSEQ_DEFINES_VH
`define FSEQ_DEFINES_VH

// Instruction opcodes
`define FSEQ_OP_BYTE_PROG    8'h02
`define FSEQ_OP_WRITE_DIS    8'h04
`define FSEQ_OP_STATUS_RD    8'h05
`define FSEQ_OP_WRITE_EN     8'h06
`define FSEQ_OP_SECTOR_ERASE 8'h20
`define FSEQ_OP_STATUS1_RD   8'h35
`define FSEQ_OP_BLK32_ERASE  8'h52
`define FSEQ_OP_CHIP_ERASE_A 8'h60
`define FSEQ_OP_BUSY_OUT_ON  8'h70
`define FSEQ_OP_BUSY_OUT_OFF 8'h80
`define FSEQ_OP_AUTO_INC     8'had
`define FSEQ_OP_CHIP_ERASE_B 8'hc7
`define FSEQ_OP_BLK64_ERASE  8'hd8

// Status register bit positions
`define FSEQ_ST_BUSY_BIT 0
`define FSEQ_ST_WEL_BIT  1
`define FSEQ_ST_AAI_BIT  6

// Erase region masks (low address bits that are ignored)
`define FSEQ_SECTOR_MASK 24'h000fff
`define FSEQ_BLK32_MASK  24'h007fff
`define FSEQ_BLK64_MASK  24'h00ffff

// Erased byte value
`define FSEQ_ERASED 8'hff

// Frame byte counts needed by the sector and block erase, program and auto-increment commands
`define FSEQ_LEN_ADDR     3'h4
`define FSEQ_LEN_PROG     3'h5
`define FSEQ_LEN_AAI_1ST  3'h6
`define FSEQ_LEN_AAI_NEXT 3'h3

// Clock rate and self-timed operation times
`define FSEQ_CLK_MHZ    125
`define FSEQ_BP_TIME_US 10
`define FSEQ_SE_TIME_MS 25
`define FSEQ_BE_TIME_MS 25
`define FSEQ_CE_TIME_MS 50
`define FSEQ_BP_CYCLES  (`FSEQ_BP_TIME_US * `FSEQ_CLK_MHZ)
`define FSEQ_SE_CYCLES  (`FSEQ_SE_TIME_MS * 1000 * `FSEQ_CLK_MHZ)
`define FSEQ_BE_CYCLES  (`FSEQ_BE_TIME_MS * 1000 * `FSEQ_CLK_MHZ)
`define FSEQ_CE_CYCLES  (`FSEQ_CE_TIME_MS * 1000 * `FSEQ_CLK_MHZ)

`endif

// file: design/fseq_sync.v
`timescale 1ns/1ps
module fseq_sync #(
  parameter       W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk_sys_in,
  input  wire         rst_b_in,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      reg q;
      // Level only moves once the second and third stages agree
      always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          s1 <= RST[i];
          s2 <= RST[i];
          s3 <= RST[i];
          q  <= RST[i];
        end else begin
          s1 <= d_in[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign q_out[i] = q;
    end
  endgenerate
endmodule // fseq_sync

// file: design/fseq_mem.v
`timescale 1ns/1ps
module fseq_mem #(
  parameter AW = 18
) (
  input  wire          clk_sys_in,
  input  wire [AW-1:0] addr_in,
  input  wire          we_in,
  input  wire [7:0]    wdata_in,
  output reg  [7:0]    rdata_out
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer k;

  // A fresh part ships fully erased
  initial begin
    for (k = 0; k < (1<<AW); k = k + 1) begin
      mem[k] = 8'hff;
    end
  end

  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule // fseq_mem

// file: design/fseq_top.v
`timescale 1ns/1ps
`include "fseq_defines.vh"
module fseq_top #(
  parameter        MEM_AW    = 18,
  parameter [31:0] BP_CYCLES = `FSEQ_BP_CYCLES,
  parameter [31:0] SE_CYCLES = `FSEQ_SE_CYCLES,
  parameter [31:0] BE_CYCLES = `FSEQ_BE_CYCLES,
  parameter [31:0] CE_CYCLES = `FSEQ_CE_CYCLES
) (
  input  wire        clk_sys_in,
  input  wire        rst_b_in,
  input  wire        sck_in,
  input  wire        cs_b_in,
  input  wire        mosi_in,
  input  wire        protect_en_in,
  input  wire [23:0] protect_base_in,
  input  wire [7:0]  second_status_in,
  output reg         miso_out,
  output reg         miso_oe_b_out,
  output reg         busy_out,
  output reg         write_enable_latch_out,
  output reg         auto_inc_out
);
  localparam [2:0] E_IDLE  = 3'd0;
  localparam [2:0] E_PRD   = 3'd1;
  localparam [2:0] E_PWR   = 3'd2;
  localparam [2:0] E_ERASE = 3'd3;
  localparam [2:0] E_WAIT  = 3'd4;
  localparam [23:0] TOP_ADDR = (24'h1 << MEM_AW) - 24'h1;

  wire       sck_q;
  wire       cs_q;
  wire       mosi_q;
  wire [7:0] mem_rd;

  reg        sck_d;
  reg        cs_d;
  reg [7:0]  sh;
  reg [2:0]  bit_cnt;
  reg [2:0]  byte_cnt;
  reg [7:0]  opcode;
  reg [23:0] cmd_addr;
  reg [7:0]  data0;
  reg [7:0]  data1;
  reg [7:0]  tx;
  reg        busy_rep;
  reg [2:0]  state;
  reg [23:0] eng_addr;
  reg [23:0] end_addr;
  reg [7:0]  pdata0;
  reg [7:0]  pdata1;
  reg        two;
  reg        word_op;
  reg [31:0] timer;
  reg [23:0] aai_addr;

  fseq_sync #(
    .W   (3),
    .RST (3'b010)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       ({sck_in, cs_b_in, mosi_in}),
    .q_out      ({sck_q, cs_q, mosi_q})
  );

  wire mem_we = (state == E_PWR) || (state == E_ERASE);
  wire [7:0] mem_wd = (state == E_ERASE) ? `FSEQ_ERASED : (mem_rd & pdata0);

  fseq_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .clk_sys_in (clk_sys_in),
    .addr_in    (eng_addr[MEM_AW-1:0]),
    .we_in      (mem_we),
    .wdata_in   (mem_wd),
    .rdata_out  (mem_rd)
  );

  wire sck_rise = sck_q & ~sck_d & ~cs_q;
  wire sck_fall = ~sck_q & sck_d & ~cs_q;
  wire cs_fall  = ~cs_q & cs_d;
  wire cs_rise  = cs_q & ~cs_d;
  wire [7:0] nb = {sh[6:0], mosi_q};
  wire follow   = auto_inc_out && (opcode == `FSEQ_OP_AUTO_INC);

  // Address bits above the array are don't care
  wire [23:0] ea = {{(24-MEM_AW){1'b0}}, cmd_addr[MEM_AW-1:0]};
  wire [23:0] limit = protect_en_in ? (protect_base_in - 24'h1) : TOP_ADDR;
  wire [23:0] word_a = {ea[23:1], 1'b0};
  wire [23:0] sec_s = ea & ~`FSEQ_SECTOR_MASK;
  wire [23:0] sec_e = ea | `FSEQ_SECTOR_MASK;
  wire [23:0] b32_s = ea & ~`FSEQ_BLK32_MASK;
  wire [23:0] b32_e = ea | `FSEQ_BLK32_MASK;
  wire [23:0] b64_s = ea & ~`FSEQ_BLK64_MASK;
  wire [23:0] b64_e = ea | `FSEQ_BLK64_MASK;
  wire frame_ok = (bit_cnt == 3'd0);
  wire can_write = write_enable_latch_out && !auto_inc_out && !busy_out;

  wire [7:0] status = {1'b0, auto_inc_out, 4'h0, write_enable_latch_out, busy_out};
  wire rd_op = (byte_cnt != 3'd0) &&
               ((opcode == `FSEQ_OP_STATUS_RD) || (opcode == `FSEQ_OP_STATUS1_RD));
  wire [7:0] rd_sel = (opcode == `FSEQ_OP_STATUS1_RD) ? second_status_in : status;

  // Serial receive: framing, bit and byte counting
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_d    <= 1'b0;
      cs_d     <= 1'b1;
      sh       <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      opcode   <= 8'h00;
      cmd_addr <= 24'h000000;
      data0    <= 8'h00;
      data1    <= 8'h00;
    end else begin
      sck_d <= sck_q;
      cs_d  <= cs_q;
      if (cs_fall) begin
        bit_cnt  <= 3'h0;
        byte_cnt <= 3'h0;
        opcode   <= 8'h00;
      end else if (sck_rise) begin
        sh      <= nb;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          if (byte_cnt != 3'h7) begin
            byte_cnt <= byte_cnt + 3'h1;
          end
          case (byte_cnt)
            3'h0: begin
              opcode <= nb;
            end
            3'h1: begin
              if (follow) begin
                data0 <= nb;
              end else begin
                cmd_addr[23:16] <= nb;
              end
            end
            3'h2: begin
              if (follow) begin
                data1 <= nb;
              end else begin
                cmd_addr[15:8] <= nb;
              end
            end
            3'h3: begin
              cmd_addr[7:0] <= nb;
            end
            3'h4: begin
              data0 <= nb;
            end
            3'h5: begin
              data1 <= nb;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Command execution and self-timed engine
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_enable_latch_out <= 1'b0;
      auto_inc_out           <= 1'b0;
      busy_out               <= 1'b0;
      busy_rep               <= 1'b0;
      state                  <= E_IDLE;
      eng_addr               <= 24'h000000;
      end_addr               <= 24'h000000;
      pdata0                 <= 8'h00;
      pdata1                 <= 8'h00;
      two                    <= 1'b0;
      word_op                <= 1'b0;
      timer                  <= 32'h0;
      aai_addr               <= 24'h000000;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        E_IDLE: begin
        end
        E_PRD: begin
          state <= E_PWR;
        end
        E_PWR: begin
          if (two) begin
            two      <= 1'b0;
            eng_addr <= {eng_addr[23:1], 1'b1};
            pdata0   <= pdata1;
            state    <= E_PRD;
          end else begin
            state <= E_WAIT;
          end
        end
        E_ERASE: begin
          if (eng_addr == end_addr) begin
            state <= E_WAIT;
          end else begin
            eng_addr <= eng_addr + 24'h1;
          end
        end
        E_WAIT: begin
          if (timer == 32'h0) begin
            state    <= E_IDLE;
            busy_out <= 1'b0;
            if (word_op && auto_inc_out) begin
              if (eng_addr >= limit) begin
                auto_inc_out           <= 1'b0;
                write_enable_latch_out <= 1'b0;
              end else begin
                aai_addr <= eng_addr + 24'h1;
              end
            end
          end
        end
        default: begin
          state <= E_IDLE;
        end
      endcase
      if (cs_rise && frame_ok && (byte_cnt != 3'h0)) begin
        case (opcode)
          `FSEQ_OP_WRITE_EN: begin
            if (!busy_out && !auto_inc_out) begin
              write_enable_latch_out <= 1'b1;
            end
          end
          `FSEQ_OP_WRITE_DIS: begin
            write_enable_latch_out <= 1'b0;
            auto_inc_out           <= 1'b0;
          end
          `FSEQ_OP_BUSY_OUT_ON: begin
            if (!busy_out && !auto_inc_out) begin
              busy_rep <= 1'b1;
            end
          end
          `FSEQ_OP_BUSY_OUT_OFF: begin
            if (!busy_out) begin
              busy_rep <= 1'b0;
            end
          end
          `FSEQ_OP_BYTE_PROG: begin
            if (can_write && (byte_cnt >= `FSEQ_LEN_PROG) &&
                !(protect_en_in && (ea >= protect_base_in))) begin
              write_enable_latch_out <= 1'b0;
              busy_out <= 1'b1;
              eng_addr <= ea;
              pdata0   <= data0;
              two      <= 1'b0;
              word_op  <= 1'b0;
              timer    <= BP_CYCLES;
              state    <= E_PRD;
            end
          end
          `FSEQ_OP_AUTO_INC: begin
            if (busy_out) begin
            end else if (!auto_inc_out) begin
              if (write_enable_latch_out && (byte_cnt >= `FSEQ_LEN_AAI_1ST) &&
                  ({word_a[23:1], 1'b1} <= limit)) begin
                auto_inc_out <= 1'b1;
                busy_out <= 1'b1;
                eng_addr <= word_a;
                pdata0   <= data0;
                pdata1   <= data1;
                two      <= 1'b1;
                word_op  <= 1'b1;
                timer    <= BP_CYCLES;
                state    <= E_PRD;
              end
            end else if (byte_cnt == `FSEQ_LEN_AAI_NEXT) begin
              busy_out <= 1'b1;
              eng_addr <= aai_addr;
              pdata0   <= data0;
              pdata1   <= data1;
              two      <= 1'b1;
              word_op  <= 1'b1;
              timer    <= BP_CYCLES;
              state    <= E_PRD;
            end
          end
          `FSEQ_OP_SECTOR_ERASE: begin
            if (can_write && (byte_cnt >= `FSEQ_LEN_ADDR) &&
                !(protect_en_in && (sec_e >= protect_base_in))) begin
              write_enable_latch_out <= 1'b0;
              busy_out <= 1'b1;
              eng_addr <= sec_s;
              end_addr <= sec_e;
              word_op  <= 1'b0;
              timer    <= SE_CYCLES;
              state    <= E_ERASE;
            end
          end
          `FSEQ_OP_BLK32_ERASE: begin
            if (can_write && (byte_cnt >= `FSEQ_LEN_ADDR) &&
                !(protect_en_in && (b32_e >= protect_base_in))) begin
              write_enable_latch_out <= 1'b0;
              busy_out <= 1'b1;
              eng_addr <= b32_s;
              end_addr <= b32_e;
              word_op  <= 1'b0;
              timer    <= BE_CYCLES;
              state    <= E_ERASE;
            end
          end
          `FSEQ_OP_BLK64_ERASE: begin
            if (can_write && (byte_cnt >= `FSEQ_LEN_ADDR) &&
                !(protect_en_in && (b64_e >= protect_base_in))) begin
              write_enable_latch_out <= 1'b0;
              busy_out <= 1'b1;
              eng_addr <= b64_s;
              end_addr <= b64_e;
              word_op  <= 1'b0;
              timer    <= BE_CYCLES;
              state    <= E_ERASE;
            end
          end
          `FSEQ_OP_CHIP_ERASE_A, `FSEQ_OP_CHIP_ERASE_B: begin
            if (can_write && !protect_en_in) begin
              write_enable_latch_out <= 1'b0;
              busy_out <= 1'b1;
              eng_addr <= 24'h000000;
              end_addr <= TOP_ADDR;
              word_op  <= 1'b0;
              timer    <= CE_CYCLES;
              state    <= E_ERASE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Serial output; driven only while selected
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      miso_out      <= 1'b0;
      miso_oe_b_out <= 1'b1;
      tx            <= 8'h00;
    end else if (cs_q) begin
      miso_oe_b_out <= 1'b1;
      miso_out      <= 1'b0;
    end else if (busy_rep && auto_inc_out) begin
      miso_oe_b_out <= 1'b0;
      miso_out      <= ~busy_out;
    end else if (sck_fall && rd_op) begin
      miso_oe_b_out <= 1'b0;
      if (bit_cnt == 3'h0) begin
        miso_out <= rd_sel[7];
        tx       <= {rd_sel[6:0], 1'b0};
      end else begin
        miso_out <= tx[7];
        tx       <= {tx[6:0], 1'b0};
      end
    end
  end
endmodule // fseq_top

// file: sim/fseq_host_model.sv
`timescale 1ns/1ps
module fseq_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      mosi_out
);
  initial begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Data line is not left showing the last bit once deselected
  task automatic sel(input bit on);
    @(posedge clk_in);
    cs_b_out <= !on;
    if (!on) mosi_out <= ~mosi_out;
  endtask

  // msb first, one frame, both clock idles
  task automatic frame(input logic [47:0] d, input int nb, input bit cpol,
                       output logic [47:0] q);
    q = '0;
    @(posedge clk_in);
    sck_out <= cpol;
    sel(1'b1);
    for (int i = 0; i < 8 * nb; i++) begin
      repeat (5) @(posedge clk_in);
      sck_out <= 1'b0;
      mosi_out <= d[47-i];
      repeat (5) @(posedge clk_in);
      sck_out <= 1'b1;
      // Late sample: the device answers through a synchroniser lag
      repeat (4) @(posedge clk_in);
      q = {q[46:0], miso_in};
    end
    repeat (5) @(posedge clk_in);
    sck_out <= cpol;
    repeat (5) @(posedge clk_in);
    sel(1'b0);
    repeat (10) @(posedge clk_in);
  endtask
endmodule // fseq_host_model

// file: sim/fseq_top_assertions.sv
`timescale 1ns/1ps
module fseq_top_checker #(
  parameter [31:0] BP_CYCLES = 32'd1250
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  input wire logic        cs_b_in,
  input wire logic        miso_oe_b_out,
  input wire logic        busy_out,
  input wire logic        write_enable_latch_out,
  input wire logic        auto_inc_out
);
  int unsigned blen;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blen <= 0;
    end else begin
      blen <= busy_out ? blen + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence cs_quiet;
    cs_b_in[*6];
  endsequence
  sequence launch;
    $rose(busy_out);
  endsequence
  oe_release_a: assert property (cs_quiet |-> miso_oe_b_out)
    else $error("output enabled while deselected");
  busy_start_a: assert property (launch |-> cs_b_in && $past(cs_b_in, 3))
    else $error("busy rose before chip select end");
  busy_len_a: assert property ($fell(busy_out) |-> blen >= BP_CYCLES - 2)
    else $error("busy too short");
  latch_use_a: assert property (launch and !auto_inc_out |-> !write_enable_latch_out)
    else $error("latch kept after start");
  busy_latch_a: assert property (launch |-> $past(write_enable_latch_out))
    else $error("operation without latch");
  auto_busy_a: assert property ($rose(auto_inc_out) |-> busy_out)
    else $error("auto mode without program");
  auto_exit_a: assert property ($fell(auto_inc_out) |-> !write_enable_latch_out)
    else $error("latch left after auto exit");
  latch_set_a: assert property ($rose(write_enable_latch_out) |-> $past(cs_b_in, 3))
    else $error("latch set inside frame");
endmodule // fseq_top_checker

bind fseq_top fseq_top_checker #(.BP_CYCLES(BP_CYCLES)) u_chk (
  .clk_sys_in             (clk_sys_in),
  .rst_b_in               (rst_b_in),
  .cs_b_in                (cs_b_in),
  .miso_oe_b_out          (miso_oe_b_out),
  .busy_out               (busy_out),
  .write_enable_latch_out (write_enable_latch_out),
  .auto_inc_out           (auto_inc_out)
);

// file: sim/tb_fseq_top.sv
`timescale 1ns/1ps
module tb_fseq_top;
  typedef struct {logic [47:0] d; int nb; bit w; bit p; bit r; logic [1:0] e;} fseq_row_t;
  logic        clk, rst_b, sck, cs_b, mosi, prot_en, miso, oe_b, busy, write_enable_latch, auto_increment_program;
  logic [23:0] prot_base;
  logic [7:0]  st2;
  logic [47:0] rx;
  int          error_cnt, checked;
  fseq_row_t   rows[14];

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  fseq_top #(.MEM_AW(13), .BP_CYCLES(1000), .SE_CYCLES(50), .BE_CYCLES(50),
             .CE_CYCLES(50)) DUT (
    .clk_sys_in(clk), .rst_b_in(rst_b), .sck_in(sck), .cs_b_in(cs_b), .mosi_in(mosi),
    .protect_en_in(prot_en), .protect_base_in(prot_base), .second_status_in(st2),
    .miso_out(miso), .miso_oe_b_out(oe_b), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch), .auto_inc_out(auto_increment_program));

  // Pull-up on the shared data line: a released line reads high
  wire         miso_line = oe_b ? 1'b1 : miso;

  fseq_host_model host (.clk_in(clk), .miso_in(miso_line), .sck_out(sck),
                        .cs_b_out(cs_b), .mosi_out(mosi));

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    @(negedge clk);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle_wait;
    for (int n = 0; busy !== 1'b0; n++) begin
      @(negedge clk);
      if (n > 20000) begin
        error_cnt++;
        end_of_test();
      end
    end
  endtask

  task automatic cmd(input logic [47:0] d, input int nb);
    host.frame(d, nb, 1'b0, rx);
  endtask

  task automatic rst_pulse(input int n);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    rst_b = 1'b0;
    prot_en = 1'b0;
    prot_base = 24'h000000;
    st2 = 8'h00;
    error_cnt = 0;
    checked = 0;
    rows = '{'{48'h060000000000, 1, 0, 0, 0, 2'b10},
             '{48'h040000000000, 1, 1, 0, 0, 2'b00},
             '{48'h02001000a500, 5, 0, 0, 0, 2'b00},
             '{48'h02001000a500, 5, 1, 1, 0, 2'b10},
             '{48'h02001000a500, 4, 1, 0, 0, 2'b10},
             '{48'h02001000a500, 5, 1, 0, 0, 2'b01},
             '{48'h200012340000, 4, 1, 0, 0, 2'b01},
             '{48'h200012340000, 4, 1, 1, 0, 2'b10},
             '{48'h520000000000, 4, 1, 0, 1, 2'b01},
             '{48'hd80000000000, 4, 1, 0, 1, 2'b01},
             '{48'hd80000000000, 4, 1, 1, 0, 2'b10},
             '{48'h600000000000, 1, 1, 0, 0, 2'b01},
             '{48'hc70000000000, 1, 1, 1, 0, 2'b10},
             '{48'hc70000000000, 1, 1, 0, 1, 2'b01}};
    rst_pulse(10);
    chk({4'h0, oe_b, busy, write_enable_latch, auto_increment_program}, 8'h08);
    foreach (rows[i]) begin
      @(posedge clk);
      prot_en <= rows[i].p;
      if (rows[i].w) cmd(48'h060000000000, 1);
      cmd(rows[i].d, rows[i].nb);
      chk({6'h0, write_enable_latch, busy}, {6'h0, rows[i].e});
      if (rows[i].r) rst_pulse(10);
      else idle_wait();
    end
    cmd(48'h060000000000, 1);
    cmd(48'h02000800c300, 5);
    host.frame(48'h050000000000, 3, 1'b1, rx);
    chk(rx[15:8], 8'h01);
    chk(rx[7:0], 8'h01);
    idle_wait();
    @(posedge clk);
    st2 <= 8'h5a;
    host.frame(48'h350000000000, 3, 1'b0, rx);
    chk(rx[15:8], 8'h5a);
    chk(rx[7:0], 8'h5a);
    cmd(48'h700000000000, 1);
    cmd(48'h060000000000, 1);
    cmd(48'had0001001122, 6);
    chk({6'h0, auto_increment_program, busy}, 8'h03);
    host.sel(1'b1);
    repeat (8) @(posedge clk);
    chk({6'h0, oe_b, miso}, 8'h00);
    host.sel(1'b0);
    idle_wait();
    host.sel(1'b1);
    repeat (8) @(posedge clk);
    chk({6'h0, oe_b, miso}, 8'h01);
    host.sel(1'b0);
    repeat (8) @(posedge clk);
    chk({7'h0, oe_b}, 8'h01);
    cmd(48'h200000000000, 4);
    chk({6'h0, auto_increment_program, busy}, 8'h02);
    cmd(48'h800000000000, 1);
    host.frame(48'h050000000000, 2, 1'b0, rx);
    chk(rx[7:0] & 8'h41, 8'h40);
    cmd(48'had3344000000, 3);
    chk({7'h0, busy}, 8'h01);
    idle_wait();
    cmd(48'h040000000000, 1);
    chk({6'h0, auto_increment_program, write_enable_latch}, 8'h00);
    idle_wait();
    @(posedge clk);
    prot_en <= 1'b1;
    prot_base <= 24'h000204;
    cmd(48'h060000000000, 1);
    cmd(48'had0002005566, 6);
    idle_wait();
    chk({7'h0, auto_increment_program}, 8'h01);
    cmd(48'had7788000000, 3);
    idle_wait();
    chk({6'h0, auto_increment_program, write_enable_latch}, 8'h00);
    end_of_test();
  end
endmodule // tb_fseq_top
